// ==== rtl/phy_ext_pkg.sv ====
// Purpose: Shared constants for the extended page 1 management register bank.
// Assumes: 5-bit management register addresses and 16-bit register data.
// Notes:   Offsets, field positions and reset values are defined here once each.
package phy_ext_pkg;
	// Register addresses.
	localparam logic [4:0]  ADDR_FIBER      = 5'h10;
	localparam logic [4:0]  ADDR_CRC        = 5'h12;
	localparam logic [4:0]  ADDR_EXT        = 5'h13;
	localparam logic [4:0]  ADDR_PAGE       = 5'h1f;
	localparam logic [4:0]  ADDR_PAGED_LO   = 5'h10;
	localparam logic [4:0]  ADDR_PAGED_HI   = 5'h1e;

	// Page-select values.
	localparam logic [15:0] PAGE_MAIN       = 16'h0000;
	localparam logic [15:0] PAGE_EXT1       = 16'h0001;
	localparam logic [15:0] PAGE_GPIO       = 16'h0010;

	// Fiber media control field positions.
	localparam int          FIB_TXRF_LSB    = 14;
	localparam int          FIB_LPRF_LSB    = 12;
	localparam int          FIB_ALLOW_1000X = 9;
	localparam int          FIB_ALLOW_100FX = 8;
	localparam int          FIB_FEF         = 6;

	// Good-CRC counter field positions and wrap point.
	localparam int          CRC_SEEN        = 15;
	localparam int          CRC_CNT_W       = 14;
	localparam int          CRC_MODULUS     = 10000;

	// Extended mode control field positions.
	localparam int          EXT_LED_LSB     = 12;
	localparam int          EXT_BLINK       = 11;
	localparam int          EXT_FAST_FAIL   = 4;
	localparam int          EXT_MDI_LSB     = 2;
	localparam int          EXT_SD_POL      = 0;

	// Reset values.
	localparam logic [15:0] PAGE_RST        = 16'h0000;
	localparam logic [1:0]  TXRF_RST        = 2'h0;
	localparam logic [1:0]  LPRF_RST        = 2'h0;
	localparam logic        ALLOW_RST       = 1'b1;
	localparam logic [3:0]  LED_EXT_RST     = 4'h0;
	localparam logic        BLINK_RST       = 1'b0;
	localparam logic        FAST_FAIL_RST   = 1'b0;
	localparam logic [1:0]  MDI_RST         = 2'h0;
	localparam logic        SD_POL_RST      = 1'b0;

	// Copper crossover selections.
	localparam logic [1:0]  MDI_AUTO        = 2'h0;
	localparam logic [1:0]  MDI_FORCE       = 2'h2;
	localparam logic [1:0]  MDI_FORCE_X     = 2'h3;

	// Where an access lands.
	typedef enum logic [1:0] {
		SPACE_LOCAL,
		SPACE_FORWARD,
		SPACE_NONE
	} space_t;
endpackage

// ==== rtl/crc_cnt_if.sv ====
// Purpose: Carrier between the register bank and its good-CRC counter.
// Assumes: All signals are on the core clock.
// Notes:   The bank drives the packet and clear pulses, the counter its state.
`timescale 1ns/100ps
`default_nettype none
interface crc_cnt_if;
	logic                                good_pkt;
	logic                                rd_clr;
	logic [phy_ext_pkg::CRC_CNT_W-1:0]   count;
	logic                                seen;

	modport ctrl (output good_pkt, output rd_clr, input count, input seen);
	modport cnt  (input good_pkt, input rd_clr, output count, output seen);
endinterface
`default_nettype wire

// ==== rtl/good_crc_counter.sv ====
// Purpose: Read-clearing modulo counter of copper packets with good CRC.
// Assumes: The packet and clear inputs are one-cycle pulses on the core clock.
// Notes:   A packet in the clearing cycle is counted after the clear.
`timescale 1ns/100ps
`default_nettype none
module good_crc_counter #(
	parameter int MODULUS = phy_ext_pkg::CRC_MODULUS
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	crc_cnt_if.cnt    bus
);
	localparam logic [phy_ext_pkg::CRC_CNT_W-1:0] CNT_LAST = phy_ext_pkg::CRC_CNT_W'(MODULUS - 1);

	logic [phy_ext_pkg::CRC_CNT_W-1:0] base;

	// The base drops to zero on a clear so that a packet arriving in the same cycle survives it.
	always_comb begin
		base = bus.rd_clr ? '0 : bus.count;
	end

	// Counter wraps instead of saturating.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus.count <= '0;
		end else if (bus.good_pkt) begin
			bus.count <= (base == CNT_LAST) ? '0 : base + 1'b1;
		end else if (bus.rd_clr) begin
			bus.count <= '0;
		end
	end

	// Packet-seen flag; a new packet beats the clear.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus.seen <= 1'b0;
		end else if (bus.good_pkt) begin
			bus.seen <= 1'b1;
		end else if (bus.rd_clr) begin
			bus.seen <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/phy_ext_page1_regs.sv ====
// Purpose: Page-select register and extended page 1 register bank of one PHY port.
// Assumes: Standard and other paged registers live outside and answer in the strobe cycle.
// Notes:   Read data is registered and stands in the cycle after the read strobe only.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Writing 0x0001 to register 31 selects extended page 1.
// - Writing 0x0000 to register 31 returns to the main register space.
// - With page 1 selected, addresses 16 to 30 reach page 1 registers.
// - Addresses 0 to 15 reach standard registers whatever the page select holds, except 0x0010.
// - Fiber bits 15:14 are sent as our remote fault; reset to 00.
// - Fiber bits 13:12 capture the partner's advertised remote fault bits.
// - Sticky bit 9, reset 1, allows 1000BASE-X link-up; clear suppresses it.
// - Sticky bit 8, reset 1, allows 100BASE-FX link-up; clear suppresses it.
// - Bit 6 flags a 100BASE-FX far end fault and clears on read.
// - Counter bit 15 shows a packet arrived since last read; clears on read.
// - Bits 13:0 count good-CRC copper packets modulo 10000, clear on read.
// - Bits 15 to 12 put LED3 to LED0 into extended mode; reset 0.
// - Bit 11 set blinks LEDs when low-power hold releases; clear suppresses.
// - Bit 4 enables the fast fail pin, port 0 only; else pin is GPIO.
// - Bits 3:2 pick crossover: 00 auto, 10 MDI, 11 MDI-X, 01 reserved.
// - Bit 0 set makes both signal detect inputs active low.
// - Fiber settings act only on SerDes ports 0 to 3.
// - Page value 0x0010 sends addresses 0 to 30 to the GPIO space.
module phy_ext_page1_regs #(
	parameter int unsigned PORT_NUM    = 0,
	parameter int unsigned MAX_SERDES  = 3,
	parameter int          CRC_MODULUS = phy_ext_pkg::CRC_MODULUS
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_soft_rst,
	// Register port.
	input  wire logic [4:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	// Forwarded accesses to the standard and other paged spaces.
	output logic             o_fwd_wr,
	output logic             o_fwd_rd,
	output logic      [4:0]  o_fwd_addr,
	output logic      [15:0] o_fwd_wdata,
	output logic      [15:0] o_fwd_page,
	input  wire logic [15:0] i_fwd_rdata,
	// Fiber media side.
	input  wire logic        i_remote_partner_rf_valid,
	input  wire logic [1:0]  i_remote_partner_rf,
	input  wire logic        i_far_end_fault,
	output logic      [1:0]  o_tx_remote_fault,
	output logic             o_allow_1000x,
	output logic             o_allow_100fx,
	// Copper packet counting.
	input  wire logic        i_good_crc_pkt,
	// Extended modes.
	output logic      [3:0]  o_led_ext_mode,
	input  wire logic        i_low_power_hold_input,
	output logic             o_led_wake_blink,
	output logic             o_force_mdi,
	output logic             o_force_mdix,
	input  wire logic [1:0]  i_signal_detect_input,
	output logic      [1:0]  o_signal_detect,
	// Fast link failure shared pin.
	input  wire logic        i_link_fail,
	input  wire logic        i_gpio_out,
	input  wire logic        i_gpio_oe,
	output logic             o_fast_fail_shared_pin,
	output logic             o_fast_fail_shared_pin_oe,
	output logic             o_fast_fail_en
);
	localparam logic IS_SERDES = (PORT_NUM <= MAX_SERDES);
	localparam logic IS_PORT0  = (PORT_NUM == 0);
	localparam int   SYNC_W    = 3;

	logic [15:0]       page_q;
	logic [1:0]        txrf_q;
	logic [1:0]        lprf_q;
	logic              allow_1000x_q;
	logic              allow_100fx_q;
	logic              fef_q;
	logic [3:0]        led_ext_q;
	logic              blink_q;
	logic              fast_fail_q;
	logic [1:0]        mdi_q;
	logic              sd_pol_q;
	logic [15:0]       rdata_q;
	logic [15:0]       local_rdata;
	phy_ext_pkg::space_t wr_space;
	phy_ext_pkg::space_t rd_space;
	logic              wr_fiber;
	logic              wr_ext;
	logic              rd_fiber;
	logic              rd_crc;
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic [SYNC_W-1:0] sync3_q;
	logic [SYNC_W-1:0] filt_q;
	logic              hold_prev_q;
	logic              wake_blink_q;
	logic [1:0]        sd_q;

	crc_cnt_if crc ();

	// Decide where an access lands; used for both the write and the read path.
	function automatic phy_ext_pkg::space_t route(input logic [4:0] addr, input logic [15:0] page);
		phy_ext_pkg::space_t sp;
		sp = phy_ext_pkg::SPACE_FORWARD;
		if (addr == phy_ext_pkg::ADDR_PAGE) begin
			sp = phy_ext_pkg::SPACE_LOCAL;
		end else if (page == phy_ext_pkg::PAGE_GPIO) begin
			sp = phy_ext_pkg::SPACE_FORWARD;
		end else if (addr < phy_ext_pkg::ADDR_PAGED_LO) begin
			sp = phy_ext_pkg::SPACE_FORWARD;
		end else if (page == phy_ext_pkg::PAGE_EXT1) begin
			if (addr == phy_ext_pkg::ADDR_FIBER || addr == phy_ext_pkg::ADDR_CRC
			    || addr == phy_ext_pkg::ADDR_EXT) begin
				sp = phy_ext_pkg::SPACE_LOCAL;
			end else begin
				sp = phy_ext_pkg::SPACE_FORWARD;
			end
		end
		return sp;
	endfunction

	// Access classification.
	always_comb begin
		wr_space = i_wr ? route(i_addr, page_q) : phy_ext_pkg::SPACE_NONE;
		rd_space = i_rd ? route(i_addr, page_q) : phy_ext_pkg::SPACE_NONE;
		wr_fiber = (wr_space == phy_ext_pkg::SPACE_LOCAL) && (i_addr == phy_ext_pkg::ADDR_FIBER);
		wr_ext   = (wr_space == phy_ext_pkg::SPACE_LOCAL) && (i_addr == phy_ext_pkg::ADDR_EXT);
		rd_fiber = (rd_space == phy_ext_pkg::SPACE_LOCAL) && (i_addr == phy_ext_pkg::ADDR_FIBER);
		rd_crc   = (rd_space == phy_ext_pkg::SPACE_LOCAL) && (i_addr == phy_ext_pkg::ADDR_CRC);
	end

	// Forwarded strobes are combinational so the outside space answers in the strobe cycle.
	assign o_fwd_wr    = (wr_space == phy_ext_pkg::SPACE_FORWARD);
	assign o_fwd_rd    = (rd_space == phy_ext_pkg::SPACE_FORWARD);
	assign o_fwd_addr  = i_addr;
	assign o_fwd_wdata = i_wdata;
	assign o_fwd_page  = page_q;

	// Page select holds any value; only the decode gives meaning to it.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			page_q <= phy_ext_pkg::PAGE_RST;
		end else if (wr_space == phy_ext_pkg::SPACE_LOCAL && i_addr == phy_ext_pkg::ADDR_PAGE) begin
			page_q <= i_wdata;
		end
	end

	// Transmitted remote fault is not sticky, so a software reset restores it too.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			txrf_q <= phy_ext_pkg::TXRF_RST;
		end else if (i_soft_rst) begin
			txrf_q <= phy_ext_pkg::TXRF_RST;
		end else if (wr_fiber) begin
			txrf_q <= i_wdata[phy_ext_pkg::FIB_TXRF_LSB +: 2];
		end
	end

	// Partner remote fault bits are captured whenever autonegotiation delivers them on a SerDes port.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lprf_q <= phy_ext_pkg::LPRF_RST;
		end else if (i_remote_partner_rf_valid && IS_SERDES) begin
			lprf_q <= i_remote_partner_rf;
		end else if (i_soft_rst) begin
			lprf_q <= phy_ext_pkg::LPRF_RST;
		end
	end

	// Link-up permissions are sticky and ignore the software reset.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			allow_1000x_q <= phy_ext_pkg::ALLOW_RST;
			allow_100fx_q <= phy_ext_pkg::ALLOW_RST;
		end else if (wr_fiber) begin
			allow_1000x_q <= i_wdata[phy_ext_pkg::FIB_ALLOW_1000X];
			allow_100fx_q <= i_wdata[phy_ext_pkg::FIB_ALLOW_100FX];
		end
	end

	// Far end fault flag; a fault in the reading cycle is kept for the next read.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fef_q <= 1'b0;
		end else if (i_far_end_fault && IS_SERDES) begin
			fef_q <= 1'b1;
		end else if (rd_fiber || i_soft_rst) begin
			fef_q <= 1'b0;
		end
	end

	// Fiber outputs fall silent on ports without SerDes media.
	always_comb begin
		o_tx_remote_fault = IS_SERDES ? txrf_q : 2'h0;
		o_allow_1000x     = IS_SERDES & allow_1000x_q;
		o_allow_100fx     = IS_SERDES & allow_100fx_q;
	end

	// Packet counter pulses into the counter module.
	assign crc.good_pkt = i_good_crc_pkt;
	assign crc.rd_clr   = rd_crc;

	good_crc_counter #(
		.MODULUS (CRC_MODULUS)
	) u_good_crc_counter (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.bus     (crc.cnt)
	);

	// Extended mode control is not sticky; the software reset returns it to defaults.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			led_ext_q   <= phy_ext_pkg::LED_EXT_RST;
			blink_q     <= phy_ext_pkg::BLINK_RST;
			fast_fail_q <= phy_ext_pkg::FAST_FAIL_RST;
			mdi_q       <= phy_ext_pkg::MDI_RST;
			sd_pol_q    <= phy_ext_pkg::SD_POL_RST;
		end else if (i_soft_rst) begin
			led_ext_q   <= phy_ext_pkg::LED_EXT_RST;
			blink_q     <= phy_ext_pkg::BLINK_RST;
			fast_fail_q <= phy_ext_pkg::FAST_FAIL_RST;
			mdi_q       <= phy_ext_pkg::MDI_RST;
			sd_pol_q    <= phy_ext_pkg::SD_POL_RST;
		end else if (wr_ext) begin
			led_ext_q   <= i_wdata[phy_ext_pkg::EXT_LED_LSB +: 4];
			blink_q     <= i_wdata[phy_ext_pkg::EXT_BLINK];
			fast_fail_q <= i_wdata[phy_ext_pkg::EXT_FAST_FAIL];
			mdi_q       <= i_wdata[phy_ext_pkg::EXT_MDI_LSB +: 2];
			sd_pol_q    <= i_wdata[phy_ext_pkg::EXT_SD_POL];
		end
	end

	// Crossover and LED mode outputs; the reserved code 01 behaves like automatic.
	always_comb begin
		o_led_ext_mode = led_ext_q;
		o_force_mdi    = (mdi_q == phy_ext_pkg::MDI_FORCE);
		o_force_mdix   = (mdi_q == phy_ext_pkg::MDI_FORCE_X);
	end

	// Three-stage synchroniser for the pin inputs: hold in bit 0, signal detects above.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end else begin
			sync1_q <= {i_signal_detect_input, i_low_power_hold_input};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// A pin change counts only once the second and third stages agree, filtering glitches.
	generate
		for (genvar g = 0; g < SYNC_W; g++) begin : g_filt
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					filt_q[g] <= 1'b0;
				end else if (sync2_q[g] == sync3_q[g]) begin
					filt_q[g] <= sync3_q[g];
				end
			end
		end
	endgenerate

	// Blink pulse on the falling edge of the filtered hold input.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hold_prev_q <= 1'b0;
			wake_blink_q <= 1'b0;
		end else begin
			hold_prev_q <= filt_q[0];
			wake_blink_q <= blink_q & hold_prev_q & ~filt_q[0];
		end
	end

	assign o_led_wake_blink = wake_blink_q;

	// Signal detect polarity; the output is always active high.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sd_q <= 2'h0;
		end else begin
			sd_q <= filt_q[2:1] ^ {2{sd_pol_q}};
		end
	end

	assign o_signal_detect = sd_q;

	// Fast fail only takes effect on port 0; elsewhere the shared pin stays a GPIO.
	always_comb begin
		o_fast_fail_en            = fast_fail_q & IS_PORT0;
		o_fast_fail_shared_pin    = o_fast_fail_en ? i_link_fail : i_gpio_out;
		o_fast_fail_shared_pin_oe = o_fast_fail_en | i_gpio_oe;
	end

	// Local read value; reserved bits stay zero.
	always_comb begin
		local_rdata = 16'h0000;
		if (i_addr == phy_ext_pkg::ADDR_PAGE) begin
			local_rdata = page_q;
		end else if (i_addr == phy_ext_pkg::ADDR_FIBER) begin
			local_rdata[phy_ext_pkg::FIB_TXRF_LSB +: 2] = txrf_q;
			local_rdata[phy_ext_pkg::FIB_LPRF_LSB +: 2] = lprf_q;
			local_rdata[phy_ext_pkg::FIB_ALLOW_1000X]   = allow_1000x_q;
			local_rdata[phy_ext_pkg::FIB_ALLOW_100FX]   = allow_100fx_q;
			local_rdata[phy_ext_pkg::FIB_FEF]           = fef_q;
		end else if (i_addr == phy_ext_pkg::ADDR_CRC) begin
			local_rdata[phy_ext_pkg::CRC_SEEN]            = crc.seen;
			local_rdata[phy_ext_pkg::CRC_CNT_W-1:0]       = crc.count;
		end else if (i_addr == phy_ext_pkg::ADDR_EXT) begin
			local_rdata[phy_ext_pkg::EXT_LED_LSB +: 4]  = led_ext_q;
			local_rdata[phy_ext_pkg::EXT_BLINK]         = blink_q;
			local_rdata[phy_ext_pkg::EXT_FAST_FAIL]     = fast_fail_q;
			local_rdata[phy_ext_pkg::EXT_MDI_LSB +: 2]  = mdi_q;
			local_rdata[phy_ext_pkg::EXT_SD_POL]        = sd_pol_q;
		end
	end

	// Read data is taken at the strobe, before any read-clear lands, and stands one cycle.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= 16'h0000;
		end else if (rd_space == phy_ext_pkg::SPACE_LOCAL) begin
			rdata_q <= local_rdata;
		end else if (rd_space == phy_ext_pkg::SPACE_FORWARD) begin
			rdata_q <= i_fwd_rdata;
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	assign o_rdata = rdata_q;
endmodule
`default_nettype wire

// ==== testbench/phy_ext_page1_chk.sv ====
// Purpose: Concurrent checks on the ports of the page 1 register bank.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Attached by bind from the testbench top file.
`timescale 1ns/100ps
`default_nettype none
module phy_ext_page1_chk #(
	parameter int unsigned PORT_NUM   = 0,
	parameter int unsigned MAX_SERDES = 3
) (
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	input wire logic        i_soft_rst,
	input wire logic [4:0]  i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic        o_fwd_wr,
	input wire logic        o_fwd_rd,
	input wire logic [4:0]  o_fwd_addr,
	input wire logic [15:0] o_fwd_wdata,
	input wire logic [15:0] o_fwd_page,
	input wire logic        i_good_crc_pkt,
	input wire logic [1:0]  o_tx_remote_fault,
	input wire logic        o_allow_1000x,
	input wire logic        o_allow_100fx,
	input wire logic [3:0]  o_led_ext_mode,
	input wire logic        o_led_wake_blink,
	input wire logic        o_force_mdi,
	input wire logic        o_force_mdix,
	input wire logic        i_link_fail,
	input wire logic        i_gpio_out,
	input wire logic        i_gpio_oe,
	input wire logic        o_fast_fail_shared_pin,
	input wire logic        o_fast_fail_shared_pin_oe,
	input wire logic        o_fast_fail_en
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	// A page 1 write that a software reset does not override.
	sequence pg1_wr(a);
		i_wr && !i_soft_rst && o_fwd_page == 16'h0001 && i_addr == a;
	endsequence
	// A counter read with no packet racing it.
	sequence crc_rd;
		i_rd && !i_good_crc_pkt && o_fwd_page == 16'h0001 && i_addr == 5'h12;
	endsequence

	page_write_a: assert property (i_wr && i_addr == 5'h1f |=> o_fwd_page == $past(i_wdata))
		else $error("page select not loaded");
	low_fwd_a: assert property ((i_wr || i_rd) && i_addr < 5'h10 |-> o_fwd_wr == i_wr && o_fwd_rd == i_rd)
		else $error("low address not forwarded");
	local_page1_a: assert property ((i_wr || i_rd) && o_fwd_page == 16'h0001
		&& i_addr inside {5'h10, 5'h12, 5'h13} |-> !o_fwd_wr && !o_fwd_rd)
		else $error("page 1 register forwarded");
	main_fwd_a: assert property ((i_wr || i_rd) && o_fwd_page inside {16'h0000, 16'h0010}
		&& i_addr != 5'h1f |-> o_fwd_wr == i_wr && o_fwd_rd == i_rd)
		else $error("main or gpio access not forwarded");
	sticky_keep_a: assert property (i_soft_rst |=> $stable(o_allow_1000x) && $stable(o_allow_100fx))
		else $error("sticky bit lost on soft reset");
	soft_clear_a: assert property (i_soft_rst |=> o_tx_remote_fault == 2'h0 && o_led_ext_mode == 4'h0)
		else $error("soft reset left fields set");
	fiber_write_a: assert property (pg1_wr(5'h10) ##0 (PORT_NUM <= MAX_SERDES)
		|=> o_tx_remote_fault == $past(i_wdata[15:14]) && o_allow_1000x == $past(i_wdata[9])
		&& o_allow_100fx == $past(i_wdata[8]))
		else $error("fiber outputs do not follow write");
	ext_write_a: assert property (pg1_wr(5'h13) |=> o_led_ext_mode == $past(i_wdata[15:12])
		&& o_force_mdi == ($past(i_wdata[3:2]) == 2'h2) && o_force_mdix == ($past(i_wdata[3:2]) == 2'h3))
		else $error("mode outputs do not follow write");
	fast_pin_a: assert property (o_fast_fail_shared_pin == (o_fast_fail_en ? i_link_fail : i_gpio_out)
		&& o_fast_fail_shared_pin_oe == (o_fast_fail_en | i_gpio_oe) && (!o_fast_fail_en || PORT_NUM == 0))
		else $error("shared pin muxing wrong");
	crc_clear_a: assert property (crc_rd ##1 (!i_good_crc_pkt && !i_wr) ##1 crc_rd |=> o_rdata == 16'h0)
		else $error("counter not cleared by read");
	blink_pulse_a: assert property (o_led_wake_blink |=> !o_led_wake_blink)
		else $error("blink longer than one cycle");
	fwd_copy_a: assert property (o_fwd_wr || o_fwd_rd |-> o_fwd_addr == i_addr && o_fwd_wdata == i_wdata)
		else $error("forwarded address or data differ");
	rdata_idle_a: assert property (!i_rd |=> o_rdata == 16'h0)
		else $error("read data stands without a read");
endmodule
`default_nettype wire

// ==== testbench/ext_space_model.sv ====
// Purpose: Stand-in for the standard and other paged register spaces.
// Assumes: Reads are answered combinationally in the strobe cycle.
// Notes:   Outside a read the data lines show a flipped copy, never stale data.
`timescale 1ns/100ps
`default_nettype none
module ext_space_model (
	input  wire logic        i_clk,
	input  wire logic        i_rd,
	input  wire logic [4:0]  i_addr,
	input  wire logic [15:0] i_page,
	output logic      [15:0] o_rdata
);
	logic [15:0] last_q = 16'h0;

	// The answer encodes page and address so a wrong route shows.
	always_comb begin
		if (i_rd)
			o_rdata = {i_page[10:0], i_addr};
		else
			o_rdata = ~last_q;
	end

	always_ff @(posedge i_clk) begin
		if (i_rd)
			last_q <= o_rdata;
	end
endmodule
`default_nettype wire

// ==== testbench/tb_phy_ext_page1_regs.sv ====
// Purpose: Self-checking bench for the page 1 register bank.
// Assumes: Port 0, a short counter modulus for the wrap case.
// Notes:   Ordinary write and read cases run from a table.
`timescale 1ns/100ps
`default_nettype none
module tb_phy_ext_page1_regs;
	localparam int MODULUS = 20;
	typedef struct packed {
		logic [4:0]  addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [9:0]  outs;
	} row_t;
	logic        i_clk = 1'b0, i_rst_n = 1'b0, i_soft_rst = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic [4:0]  i_addr = 5'h0;
	logic [15:0] i_wdata = 16'h0, o_rdata, o_fwd_wdata, o_fwd_page, i_fwd_rdata, got;
	logic        o_fwd_wr, o_fwd_rd, i_remote_partner_rf_valid = 1'b0, i_far_end_fault = 1'b0;
	logic [4:0]  o_fwd_addr;
	logic [1:0]  i_remote_partner_rf = 2'h0, o_tx_remote_fault, i_signal_detect_input = 2'h0, o_signal_detect;
	logic        o_allow_1000x, o_allow_100fx, i_good_crc_pkt = 1'b0, i_low_power_hold_input = 1'b0;
	logic [3:0]  o_led_ext_mode;
	logic        o_led_wake_blink, o_force_mdi, o_force_mdix, i_link_fail = 1'b0, i_gpio_out = 1'b0;
	logic        i_gpio_oe = 1'b0, o_fast_fail_shared_pin, o_fast_fail_shared_pin_oe, o_fast_fail_en;
	int          n_fail = 0, n_compared = 0, cycles = 0, seen;
	row_t        rows[7] = '{
		'{5'h10, 16'hffff, 16'hc300, 10'h3c0}, '{5'h10, 16'h0000, 16'h0000, 10'h000},
		'{5'h10, 16'h4100, 16'h4100, 10'h140}, '{5'h13, 16'hffff, 16'hf81d, 10'h17d},
		'{5'h13, 16'h0004, 16'h0004, 10'h140}, '{5'h13, 16'h0008, 16'h0008, 10'h142},
		'{5'h13, 16'h5000, 16'h5000, 10'h154}};

	phy_ext_page1_regs #(.CRC_MODULUS(MODULUS)) dut_u (.i_clk, .i_rst_n, .i_soft_rst, .i_addr, .i_wdata,
		.i_wr, .i_rd, .o_rdata, .o_fwd_wr, .o_fwd_rd, .o_fwd_addr, .o_fwd_wdata, .o_fwd_page, .i_fwd_rdata,
		.i_remote_partner_rf_valid, .i_remote_partner_rf, .i_far_end_fault, .o_tx_remote_fault, .o_allow_1000x,
		.o_allow_100fx, .i_good_crc_pkt, .o_led_ext_mode, .i_low_power_hold_input, .o_led_wake_blink,
		.o_force_mdi, .o_force_mdix, .i_signal_detect_input, .o_signal_detect, .i_link_fail, .i_gpio_out,
		.i_gpio_oe, .o_fast_fail_shared_pin, .o_fast_fail_shared_pin_oe, .o_fast_fail_en);
	ext_space_model ext_u (.i_clk, .i_rd(o_fwd_rd), .i_addr(o_fwd_addr), .i_page(o_fwd_page),
		.o_rdata(i_fwd_rdata));

	// Clock at 5 ns period.
	initial begin
		forever #2.5 i_clk = ~i_clk;
	end

	// A hang ends the run as a failure.
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 4000) begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("Compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe, so it is taken there.
	task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, e);
	endtask

	// Raises one event input for n cycles: 0 packet, 1 far end fault, 2 partner fault, 3 soft reset.
	task automatic pulse(input int which, input int n);
		@(posedge i_clk);
		case (which)
			0: i_good_crc_pkt <= 1'b1;
			1: i_far_end_fault <= 1'b1;
			2: begin
				i_remote_partner_rf_valid <= 1'b1;
				i_remote_partner_rf <= 2'h2;
			end
			default: i_soft_rst <= 1'b1;
		endcase
		repeat (n) @(posedge i_clk);
		{i_good_crc_pkt, i_far_end_fault, i_remote_partner_rf_valid, i_soft_rst} <= 4'h0;
	endtask

	initial begin
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		wr(5'h1f, 16'h0001);
		rdchk(5'h1f, 16'h0001);
		rdchk(5'h10, 16'h0300);
		rdchk(5'h12, 16'h0000);
		rdchk(5'h13, 16'h0000);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rdchk(rows[i].addr, rows[i].rdata);
			chk({6'h0, o_tx_remote_fault, o_allow_1000x, o_allow_100fx, o_led_ext_mode, o_force_mdi, o_force_mdix},
				{6'h0, rows[i].outs});
		end
		pulse(0, 3);
		rdchk(5'h12, 16'h8003);
		rdchk(5'h12, 16'h0000);
		pulse(0, MODULUS + 1);
		rdchk(5'h12, 16'h8001);
		pulse(1, 1);
		rdchk(5'h10, 16'h4140);
		rdchk(5'h10, 16'h4100);
		pulse(2, 1);
		rdchk(5'h10, 16'h6100);
		pulse(3, 1);
		rdchk(5'h10, 16'h0100);
		rdchk(5'h13, 16'h0000);
		// Pins pass a filter of a few cycles, so each value settles before it is checked.
		for (int p = 0; p < 2; p++) begin
			for (int s = 0; s < 4; s++) begin
				wr(5'h13, 16'(p));
				i_signal_detect_input <= 2'(s);
				repeat (10) @(posedge i_clk);
				#1 chk({14'h0, o_signal_detect}, {14'h0, 2'(s) ^ {2{p[0]}}});
			end
		end
		for (int b = 0; b < 2; b++) begin
			wr(5'h13, b[0] ? 16'h0800 : 16'h0000);
			i_low_power_hold_input <= 1'b1;
			repeat (10) @(posedge i_clk);
			i_low_power_hold_input <= 1'b0;
			seen = 0;
			repeat (14) begin
				@(posedge i_clk);
				#1 seen += int'(o_led_wake_blink === 1'b1);
			end
			chk(16'(seen), 16'(b));
		end
		@(posedge i_clk);
		i_gpio_out <= 1'b1;
		i_gpio_oe <= 1'b1;
		wr(5'h13, 16'h0010);
		#1 chk({13'h0, o_fast_fail_en, o_fast_fail_shared_pin, o_fast_fail_shared_pin_oe}, 16'h0005);
		wr(5'h13, 16'h0000);
		#1 chk({13'h0, o_fast_fail_en, o_fast_fail_shared_pin, o_fast_fail_shared_pin_oe}, 16'h0003);
		rdchk(5'h05, 16'h0025);
		rdchk(5'h11, 16'h0031);
		wr(5'h1f, 16'h0010);
		rdchk(5'h13, 16'h0213);
		wr(5'h1f, 16'h0000);
		rdchk(5'h10, 16'h0010);
		// A write on the main page must go outside and leave the fiber register alone.
		wr(5'h10, 16'h1234);
		wr(5'h1f, 16'h0001);
		rdchk(5'h10, 16'h0100);
		wr(5'h10, 16'h0000);
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		#1 chk({14'h0, o_allow_1000x, o_allow_100fx}, 16'h0003);
		chk(o_fwd_page, 16'h0000);
		give_verdict();
	end
endmodule

bind phy_ext_page1_regs phy_ext_page1_chk #(.PORT_NUM(PORT_NUM), .MAX_SERDES(MAX_SERDES)) chk_u (.i_clk,
	.i_rst_n, .i_soft_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_fwd_wr, .o_fwd_rd, .o_fwd_page,
	.i_good_crc_pkt, .o_tx_remote_fault, .o_allow_1000x, .o_allow_100fx, .o_led_ext_mode, .o_led_wake_blink,
	.o_force_mdi, .o_force_mdix, .i_link_fail, .i_gpio_out, .i_gpio_oe, .o_fast_fail_shared_pin,
	.o_fast_fail_shared_pin_oe, .o_fast_fail_en, .o_fwd_addr, .o_fwd_wdata);
`default_nettype wire
